/* File: rtl/psr_defs.vh */
// Purpose: Constants of the precise sample record unit
// Assumes: APB byte addresses, 32-bit data
// Notes:   Included by psr_top.v only
`ifndef PSR_DEFS_VH
`define PSR_DEFS_VH
// Counter shape
`define PSR_CNT_W        48
`define PSR_CNT_W8       8'd48
`define PSR_NUM_GP       4
`define PSR_NUM_FX       3
// Event select fields
`define PSR_EVS_EN       22
`define PSR_EVS_ANYTHR   21
`define PSR_OFFC_CODE0   8'hB7
`define PSR_OFFC_CODE1   8'hBB
// Register byte offsets
`define PSR_A_EVSEL0     8'h00
`define PSR_A_GPCNT0     8'h10
`define PSR_A_FXCNT0     8'h30
`define PSR_A_FXCTRL     8'h48
`define PSR_A_SAMPEN_LO  8'h4C
`define PSR_A_SAMPEN_HI  8'h50
`define PSR_A_OVF_LO     8'h54
`define PSR_A_OVF_HI     8'h58
`define PSR_A_OVF_CLR    8'h5C
`define PSR_A_PERFCAP    8'h60
`define PSR_A_MISC       8'h64
`define PSR_A_ID_WIDTH   8'h68
`define PSR_A_ID_FEAT    8'h6C
`define PSR_A_INDEX      8'h70
`define PSR_A_ABSMAX     8'h74
`define PSR_A_OFFC0      8'h78
`define PSR_A_OFFC1      8'h7C
`define PSR_A_STATUS     8'h80
// Read-only field positions and values
`define PSR_CAP_FMT_POS  8
`define PSR_CAP_FMT      4'h1
`define PSR_CAP_TRAP_POS 6
`define PSR_MISC_PM_POS  7
`define PSR_MISC_PS_POS  12
`define PSR_ID_W_POS     16
`define PSR_ID_DS64_POS  2
`define PSR_OVF_FX_POS   32
// Record layout, one 64-bit field each
`define PSR_REC_FIELDS   5'd22
`define PSR_REC_BYTES    32'h000000B0
`define PSR_F_FLAGS      5'd0
`define PSR_F_IP         5'd1
`define PSR_F_GPR0       5'd2
`define PSR_F_OVF        5'd18
`define PSR_F_LINADDR    5'd19
`define PSR_F_DSRC       5'd20
`define PSR_F_LAT        5'd21
`endif

/* File: rtl/psr_top.v */
// Purpose: Counters and precise sampling with record writer
// Assumes: Core stalls while assist_busy is high
// Notes:   APB slave, one wait state on every access
//
// Notes on behaviour
// - Four general counters, three fixed, selects
// - General counters 48 bits, width reported
// - Select bit 21 sets thread qualification
// - Misc bits 7, 12 report support
// - Four capture enable bits per counter
// - Four latency enable bits per counter
// - Overflow with capture enable arms only
// - Armed: next event writes one record
// - Capability bits 11:8 report format 0001
// - Capability bit 6 reports assist behaviour
// - Recorded pointer is the following instruction
// - Registers show post-retirement state
// - Every record field is 64 bits
// - Same layout any mode, bit 2 reported
// - Flags 00H, pointer 08H, registers to 88H
// - Outside long mode 32-bit, missing zero
// - Status 90H, address 98H, source, latency A8H
// - Status snapshot taken before the assist
// - Latency from first dispatch, demand loads
// - Two offcore filters with event codes
// - Index advances after each record
// - No record when index equals maximum
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "psr_defs.vh"
module psr_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [3:0]  evt_gp,
  input  wire [3:0]  evt_own_thr,
  input  wire [2:0]  evt_fx,
  input  wire        offc_valid,
  input  wire [15:0] offc_req,
  input  wire [15:0] offc_resp,
  input  wire [63:0] ret_flags,
  input  wire [63:0] ret_next_ip,
  input  wire [63:0] ret_lin_addr,
  input  wire [63:0] ret_dsrc,
  input  wire [15:0] ret_load_lat,
  input  wire        ret_demand_load,
  input  wire        long_mode,
  output reg  [3:0]  gpr_idx,
  input  wire [63:0] gpr_data,
  output reg         assist_busy,
  output reg         mem_valid,
  output reg  [31:0] mem_addr,
  output reg  [63:0] mem_data,
  input  wire        mem_ready
);

  localparam ST_IDLE = 2'd0;
  localparam ST_LOAD = 2'd1;
  localparam ST_WAIT = 2'd2;
  localparam ST_DONE = 2'd3;

  ////////////////////////////////////////////////////////////////////////
  // Storage
  reg [31:0]          evsel_q [0:3];
  reg [47:0]          gp_cnt_q [0:3];
  reg [47:0]          fx_cnt_q [0:2];
  reg [2:0]           fx_en_q;
  reg [3:0]           cap_en_q;
  reg [3:0]           lat_en_q;
  reg [3:0]           ovf_gp_q;
  reg [2:0]           ovf_fx_q;
  reg [3:0]           armed_q;
  reg [31:0]          index_q;
  reg [31:0]          absmax_q;
  reg [31:0]          offc_q [0:1];
  reg [1:0]           state_q;
  reg [4:0]           fld_q;
  reg [63:0]          snap_flags_q;
  reg [63:0]          snap_ip_q;
  reg [63:0]          snap_la_q;
  reg [63:0]          snap_dsrc_q;
  reg [63:0]          snap_ovf_q;
  reg [15:0]          snap_lat_q;
  reg                 snap_long_q;
  reg                 snap_lat_ok_q;
  reg [1:0]           trig_ix_q;
  // Lowest set bit wins, index order priority
  function [1:0] first_one;
    input [3:0] v;
    begin
      if (v[0])
        first_one = 2'd0;
      else if (v[1])
        first_one = 2'd1;
      else if (v[2])
        first_one = 2'd2;
      else
        first_one = 2'd3;
    end
  endfunction
  // Offcore filter match: request type and response pattern
  function offc_match;
    input [31:0] f;
    input [15:0] rq;
    input [15:0] rs;
    begin
      offc_match = (|(rq & f[15:0])) & (f[16] | (|(rs[15:1] & f[31:17])));
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Event qualification per general counter
  wire       hit0 = offc_valid & offc_match(offc_q[0], offc_req, offc_resp);
  wire       hit1 = offc_valid & offc_match(offc_q[1], offc_req, offc_resp);
  wire [3:0] gp_inc;
  wire [3:0] gp_wrap;
  genvar g;
  generate
    for (g = 0; g < `PSR_NUM_GP; g = g + 1) begin : g_gp
      wire [7:0] code = evsel_q[g][7:0];
      wire       is0  = (code == `PSR_OFFC_CODE0);
      wire       is1  = (code == `PSR_OFFC_CODE1);
      wire       thr  = evt_own_thr[g] | evsel_q[g][`PSR_EVS_ANYTHR];
      assign gp_inc[g]  = evsel_q[g][`PSR_EVS_EN] &
                          ((is0 & hit0) | (is1 & hit1) |
                           (~is0 & ~is1 & evt_gp[g] & thr));
      assign gp_wrap[g] = gp_inc[g] & (&gp_cnt_q[g]);
    end
  endgenerate
  // Fixed counter increments and wraps
  wire [2:0] fx_inc  = fx_en_q & evt_fx;
  wire [2:0] fx_wrap = fx_inc & {&fx_cnt_q[2], &fx_cnt_q[1], &fx_cnt_q[0]};

  // Armed counter sees its next event while idle and buffer has room
  wire       idle    = (state_q == ST_IDLE);
  wire       full    = (index_q == absmax_q);
  wire [3:0] trig    = armed_q & gp_inc & {4{idle & ~full}};
  wire [1:0] trig_ix = first_one(trig);

  ////////////////////////////////////////////////////////////////////////
  // APB decode
  wire       acc     = psel & penable;
  wire [7:0] a8      = paddr[7:0];
  wire [1:0] cix     = a8[4:3];
  wire [1:0] fix     = (a8 < 8'h38) ? 2'd0 : ((a8 < 8'h40) ? 2'd1 : 2'd2);
  wire       in_evs  = (a8 < `PSR_A_GPCNT0);
  wire       in_gpc  = (a8 >= `PSR_A_GPCNT0) & (a8 < `PSR_A_FXCNT0);
  wire       in_fxc  = (a8 >= `PSR_A_FXCNT0) & (a8 < `PSR_A_FXCTRL);
  wire       mapped  = (paddr[11:8] == 4'h0) & (paddr[1:0] == 2'b00) &
                       (a8 <= `PSR_A_STATUS);
  wire       wr_take = acc & pwrite & pready & mapped; // Refused writes land nowhere
  wire [63:0] ovf_all = {29'h0, ovf_fx_q, 28'h0, ovf_gp_q};

  // Read data mux
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h0;
    if (in_evs)
      rd_d = evsel_q[a8[3:2]];
    else if (in_gpc)
      rd_d = a8[2] ? {16'h0, gp_cnt_q[cix - 2'd2][47:32]} : gp_cnt_q[cix - 2'd2][31:0];
    else if (in_fxc)
      rd_d = a8[2] ? {16'h0, fx_cnt_q[fix][47:32]} : fx_cnt_q[fix][31:0];
    else begin
      case (a8)
        `PSR_A_FXCTRL:    rd_d = {29'h0, fx_en_q};
        `PSR_A_SAMPEN_LO: rd_d = {28'h0, cap_en_q};
        `PSR_A_SAMPEN_HI: rd_d = {28'h0, lat_en_q};
        `PSR_A_OVF_LO:    rd_d = ovf_all[31:0];
        `PSR_A_OVF_HI:    rd_d = ovf_all[63:32];
        `PSR_A_PERFCAP:   rd_d = ({28'h0, `PSR_CAP_FMT} << `PSR_CAP_FMT_POS) |
                                 (32'h1 << `PSR_CAP_TRAP_POS);
        `PSR_A_MISC:      rd_d = (32'h1 << `PSR_MISC_PM_POS) |
                                 (32'h1 << `PSR_MISC_PS_POS);
        `PSR_A_ID_WIDTH:  rd_d = {24'h0, `PSR_CNT_W8} << `PSR_ID_W_POS;
        `PSR_A_ID_FEAT:   rd_d = 32'h1 << `PSR_ID_DS64_POS;
        `PSR_A_INDEX:     rd_d = index_q;
        `PSR_A_ABSMAX:    rd_d = absmax_q;
        `PSR_A_OFFC0:     rd_d = offc_q[0];
        `PSR_A_OFFC1:     rd_d = offc_q[1];
        `PSR_A_STATUS:    rd_d = {26'h0, full, ~idle, armed_q};
        default:          rd_d = 32'h0;
      endcase
    end
  end

  // One wait state, answer from flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (acc & ~pready) begin
      pready  <= 1'b1;
      prdata  <= (pwrite | ~mapped) ? 32'h0 : rd_d;
      pslverr <= ~mapped;
    end else begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Record field word, mode masked
  reg [63:0] word_d;
  always @* begin
    word_d = 64'h0;
    if (fld_q == `PSR_F_FLAGS)
      word_d = snap_flags_q;
    else if (fld_q == `PSR_F_IP)
      word_d = snap_ip_q;
    else if (fld_q < `PSR_F_OVF)
      word_d = (~snap_long_q & gpr_idx[3]) ? 64'h0 : gpr_data;
    else if (fld_q == `PSR_F_OVF)
      word_d = snap_ovf_q;
    else if (fld_q == `PSR_F_LINADDR)
      word_d = snap_la_q;
    else if (fld_q == `PSR_F_DSRC)
      word_d = snap_dsrc_q;
    else
      word_d = snap_lat_ok_q ? {48'h0, snap_lat_q} : 64'h0;
    if (~snap_long_q & (fld_q < `PSR_F_OVF))
      word_d = {32'h0, word_d[31:0]};
  end

  ////////////////////////////////////////////////////////////////////////
  // Assist sequencer writing one 64-bit field per beat
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q       <= ST_IDLE;
      fld_q         <= 5'd0;
      gpr_idx       <= 4'h0;
      assist_busy   <= 1'b0;
      mem_valid     <= 1'b0;
      mem_addr      <= 32'h0;
      mem_data      <= 64'h0;
      snap_flags_q  <= 64'h0;
      snap_ip_q     <= 64'h0;
      snap_la_q     <= 64'h0;
      snap_dsrc_q   <= 64'h0;
      snap_ovf_q    <= 64'h0;
      snap_lat_q    <= 16'h0;
      snap_long_q   <= 1'b0;
      snap_lat_ok_q <= 1'b0;
      trig_ix_q     <= 2'd0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (|trig) begin
            state_q       <= ST_LOAD;
            fld_q         <= 5'd0;
            gpr_idx       <= 4'h0;
            assist_busy   <= 1'b1;
            snap_flags_q  <= ret_flags;
            snap_ip_q     <= ret_next_ip;
            snap_la_q     <= ret_lin_addr;
            snap_dsrc_q   <= ret_dsrc;
            snap_ovf_q    <= ovf_all;
            snap_lat_q    <= ret_load_lat;
            snap_long_q   <= long_mode;
            snap_lat_ok_q <= lat_en_q[trig_ix] & ret_demand_load;
            trig_ix_q     <= trig_ix;
          end
        end
        ST_LOAD: begin
          mem_valid <= 1'b1;
          mem_addr  <= index_q + {24'h0, fld_q, 3'b000};
          mem_data  <= word_d;
          state_q   <= ST_WAIT;
        end
        ST_WAIT: begin
          if (mem_ready) begin
            mem_valid <= 1'b0;
            if (fld_q == `PSR_REC_FIELDS - 5'd1) begin
              state_q <= ST_DONE;
            end else begin
              fld_q   <= fld_q + 5'd1;
              gpr_idx <= fld_q[3:0] - 4'd1; // Next field's register
              state_q <= ST_LOAD;
            end
          end
        end
        default: begin
          assist_busy <= 1'b0;
          state_q     <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counters, enables, status and buffer pointers
  integer i;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 4; i = i + 1) begin
        evsel_q[i]  <= 32'h0;
        gp_cnt_q[i] <= 48'h0;
      end
      for (i = 0; i < 3; i = i + 1)
        fx_cnt_q[i] <= 48'h0;
      offc_q[0] <= 32'h0;
      offc_q[1] <= 32'h0;
      fx_en_q   <= 3'h0;
      cap_en_q  <= 4'h0;
      lat_en_q  <= 4'h0;
      ovf_gp_q  <= 4'h0;
      ovf_fx_q  <= 3'h0;
      armed_q   <= 4'h0;
      index_q   <= 32'h0;
      absmax_q  <= 32'h0;
    end else begin
      // Hardware counting, software write below takes the word
      for (i = 0; i < 4; i = i + 1)
        if (gp_inc[i])
          gp_cnt_q[i] <= gp_cnt_q[i] + 48'h1;
      for (i = 0; i < 3; i = i + 1)
        if (fx_inc[i])
          fx_cnt_q[i] <= fx_cnt_q[i] + 48'h1;
      if (wr_take) begin
        if (in_evs)
          evsel_q[a8[3:2]] <= pwdata;
        else if (in_gpc & a8[2])
          gp_cnt_q[cix - 2'd2][47:32] <= pwdata[15:0];
        else if (in_gpc)
          gp_cnt_q[cix - 2'd2][31:0] <= pwdata;
        else if (in_fxc & a8[2])
          fx_cnt_q[fix][47:32] <= pwdata[15:0];
        else if (in_fxc)
          fx_cnt_q[fix][31:0] <= pwdata;
        else begin
          case (a8)
            `PSR_A_FXCTRL:    fx_en_q   <= pwdata[2:0];
            `PSR_A_SAMPEN_LO: cap_en_q  <= pwdata[3:0];
            `PSR_A_SAMPEN_HI: lat_en_q  <= pwdata[3:0];
            `PSR_A_INDEX:     index_q   <= pwdata;
            `PSR_A_ABSMAX:    absmax_q  <= pwdata;
            `PSR_A_OFFC0:     offc_q[0] <= pwdata;
            `PSR_A_OFFC1:     offc_q[1] <= pwdata;
            default:          fx_en_q   <= fx_en_q;
          endcase
        end
      end
      // Write-one clear, a new overflow in the same cycle wins
      if (wr_take & (a8 == `PSR_A_OVF_CLR)) begin
        ovf_gp_q <= (ovf_gp_q & ~pwdata[3:0]) | gp_wrap;
        ovf_fx_q <= (ovf_fx_q & ~pwdata[6:4]) | fx_wrap;
      end else begin
        ovf_gp_q <= ovf_gp_q | gp_wrap;
        ovf_fx_q <= ovf_fx_q | fx_wrap;
      end
      // Arm on wrap, disarm after the record is out
      if (state_q == ST_DONE)
        armed_q <= ((armed_q & ~(4'h1 << trig_ix_q)) | gp_wrap) & cap_en_q;
      else
        armed_q <= (armed_q | (gp_wrap & cap_en_q)) & cap_en_q;
      if ((state_q == ST_DONE) & ~(wr_take & (a8 == `PSR_A_INDEX)))
        index_q <= index_q + `PSR_REC_BYTES;
    end
  end

endmodule
`default_nettype wire

/* File: sim/psr_mem_model.sv */
// Purpose: Memory side taking sample record beats
// Assumes: A beat waits on mem_valid until accepted
// Notes:   Slow mode accepts only every fourth cycle
`timescale 1ns/10ps
`default_nettype none
module psr_mem_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic slow,
  input  wire logic mem_valid,
  output var  logic mem_ready
);
  logic [1:0] tick_q;
  // One-cycle accept pulse while a beat waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q    <= 2'h0;
      mem_ready <= 1'b0;
    end else begin
      tick_q    <= tick_q + 2'h1;
      mem_ready <= mem_valid && !mem_ready && (!slow || tick_q == 2'h3);
    end
  end
endmodule
`default_nettype wire

/* File: sim/psr_top_props.sv */
// Purpose: Port assertions of the sample record unit
// Assumes: Bound to psr_top from the bench top file
// Notes:   Beat count and last address kept in helper logic
`timescale 1ns/10ps
`default_nettype none
module psr_top_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        assist_busy,
  input wire logic        mem_valid,
  input wire logic [31:0] mem_addr,
  input wire logic [63:0] mem_data,
  input wire logic        mem_ready
);
  logic [4:0]  bcnt_q;
  logic [31:0] last_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Beats accepted in the running record
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcnt_q <= 5'h0;
      last_q <= 32'h0;
    end else begin
      if (!assist_busy) bcnt_q <= 5'h0;
      else if (mem_valid && mem_ready) bcnt_q <= bcnt_q + 5'h1;
      if (mem_valid && mem_ready) last_q <= mem_addr;
    end
  end
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_ready_time: assert property ($rose(penable) && psel |=> pready) else $error("late pready");
  a_rdata_idle: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("prdata not zero");
  a_err_map: assert property (pready |-> pslverr == (paddr > 12'h080 || paddr[1:0] != 2'h0))
    else $error("wrong pslverr");
  a_rec_start: assert property ($rose(assist_busy) |=> mem_valid)
    else $error("record start late");
  a_beat_hold: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr)
    && $stable(mem_data)) else $error("beat not held");
  a_beat_gap: assert property (mem_valid && mem_ready |=> !mem_valid ##1
    (mem_valid || !assist_busy)) else $error("beat spacing");
  a_beat_stride: assert property ($rose(mem_valid) && bcnt_q != 5'h0 |->
    mem_addr == last_q + 32'h8) else $error("field stride");
  a_rec_len: assert property ($fell(assist_busy) |-> bcnt_q == 5'h16)
    else $error("record length");
  a_valid_busy: assert property (mem_valid |-> assist_busy) else $error("beat outside assist");
  c_record: cover property ($fell(assist_busy));
  c_stall: cover property (mem_valid && !mem_ready ##1 mem_valid);
  c_refused: cover property (pready && pslverr);
endmodule
`default_nettype wire

/* File: sim/psr_top_bench.sv */
// Purpose: Self-checking bench of the sample record unit
// Assumes: Bench is APB master and drives the core side
// Notes:   Expected results queue up, monitors compare
`timescale 1ns/10ps
`default_nettype none
module psr_top_bench;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        offc_valid = 1'b0, ret_demand_load = 1'b0, long_mode = 1'b0, slow = 1'b0;
  logic        pready, pslverr, assist_busy, mem_valid, mem_ready;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rs = 32'h15, prdata, mem_addr;
  logic [15:0] offc_req = 16'h0, offc_resp = 16'h0, ret_load_lat = 16'h0;
  logic [63:0] ret_flags = '0, ret_next_ip = '0, ret_lin_addr = '0, ret_dsrc = '0;
  logic [63:0] gmask = '0, gpr_data, mem_data;
  logic [3:0]  evt_gp = 4'h0, evt_own_thr = 4'h0, gpr_idx;
  logic [2:0]  evt_fx = 3'h0;
  logic [32:0] aq[$];
  logic [95:0] mq[$];
  int          err_total = 0, num_checks = 0;
  psr_top i_psr_top (.*);
  psr_mem_model i_psr_mem_model (.*);
  assign gpr_data = {16{gpr_idx}} ^ gmask;
  always #4 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  function automatic logic [63:0] r64();
    rs = xs(xs(rs));
    return {rs, xs(rs)};
  endfunction
  task automatic report_and_stop;
    if (err_total == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cmp_mem(input logic [95:0] got, input logic [95:0] want);
    num_checks++;
    if (got !== want) begin
      err_total++;
      $display("mismatch at %0t got %h expected %h", $time, got, want);
    end
  endtask
  task automatic cmp_apb(input logic [32:0] got, input logic [32:0] want);
    cmp_mem({63'h0, got}, {63'h0, want});
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int n;
    aq.push_back(e);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) err_total++;
    if (n >= 40) report_and_stop;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask
  task automatic pulse(input logic [3:0] g, input logic [3:0] o);
    @(posedge pclk);
    evt_gp      <= g;
    evt_own_thr <= o;
    @(posedge pclk);
    evt_gp <= 4'h0;
  endtask
  // Fresh retirement values; registers carry the index in each nibble, XORed with gmask
  task automatic core_rand;
    ret_flags    <= r64();
    ret_next_ip  <= r64();
    ret_lin_addr <= r64();
    ret_dsrc     <= r64();
    gmask        <= r64();
    ret_load_lat <= 16'(r64());
  endtask
  task automatic exp_rec(input logic [31:0] base, input logic [63:0] ovf);
    logic [63:0] v;
    for (int k = 0; k < 22; k++) begin
      v = k == 0 ? ret_flags : k == 1 ? ret_next_ip : {16{4'(k - 2)}} ^ gmask;
      if (k > 17) v = k == 18 ? ovf : k == 19 ? ret_lin_addr : k == 20 ? ret_dsrc :
        {48'h0, ret_load_lat & {16{ret_demand_load}}};
      if (!long_mode && k < 18) v = k > 9 ? 64'h0 : {32'h0, v[31:0]};
      mq.push_back({base + 32'(8 * k), v});
    end
  endtask
  task automatic wait_rec;
    int n;
    n = 0;
    while ((mq.size() != 0 || assist_busy !== 1'b0) && n < 600) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 600) err_total++;
    if (n >= 600) report_and_stop;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Monitor of APB answers and accepted record beats
  always @(posedge pclk) begin
    if (pready === 1'b1) cmp_apb({pslverr, prdata}, aq.size() ? aq.pop_front() : 33'bx);
    if (mem_valid === 1'b1 && mem_ready === 1'b1)
      cmp_mem({mem_addr, mem_data}, mq.size() ? mq.pop_front() : 96'bx);
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h060, 32'h00000140);
    rd(12'h064, 32'h00001080);
    rd(12'h068, 32'h00300000);
    rd(12'h06C, 32'h00000004);
    wr(12'h060, 32'hFFFFFFFF);
    rd(12'h060, 32'h00000140);
    apb(1'b0, 12'h084, 32'h0, 33'h100000000);
    wr(12'h000, 32'h00400000);
    wr(12'h004, 32'h00600000);
    wr(12'h010, 32'hFFFFFFFF);
    wr(12'h014, 32'h0000FFFF);
    wr(12'h018, 32'hFFFFFFFF);
    wr(12'h01C, 32'h0000FFFF);
    wr(12'h04C, 32'h00000001);
    wr(12'h050, 32'h00000001);
    wr(12'h070, 32'h00001000);
    wr(12'h074, 32'h00002000);
    pulse(4'h3, 4'h0);
    rd(12'h054, 32'h00000002);
    rd(12'h080, 32'h00000000);
    pulse(4'h1, 4'h1);
    rd(12'h080, 32'h00000001);
    long_mode       <= 1'b1;
    ret_demand_load <= 1'b1;
    core_rand;
    @(posedge pclk);
    exp_rec(32'h00001000, 64'h3);
    pulse(4'h1, 4'h1);
    wait_rec;
    rd(12'h070, 32'h000010B0);
    rd(12'h080, 32'h00000000);
    rd(12'h010, 32'h00000001);
    // Full buffer: counter stays armed, nothing written
    wr(12'h074, 32'h000010B0);
    wr(12'h010, 32'hFFFFFFFF);
    wr(12'h014, 32'h0000FFFF);
    pulse(4'h1, 4'h1);
    pulse(4'h1, 4'h1);
    rd(12'h080, 32'h00000021);
    long_mode       <= 1'b0;
    ret_demand_load <= 1'b0;
    slow            <= 1'b1;
    core_rand;
    @(posedge pclk);
    exp_rec(32'h000010B0, 64'h3);
    wr(12'h074, 32'h00002000);
    pulse(4'h1, 4'h1);
    wait_rec;
    rd(12'h070, 32'h00001160);
    // Refused write, fixed counter wrap and offcore filter counting
    apb(1'b1, 12'h118, 32'h00000005, 33'h100000000);
    rd(12'h018, 32'h00000000);
    wr(12'h048, 32'h00000001);
    wr(12'h030, 32'hFFFFFFFF);
    wr(12'h034, 32'h0000FFFF);
    wr(12'h008, 32'h004000B7);
    wr(12'h078, 32'h00010001);
    @(posedge pclk);
    evt_fx     <= 3'h1;
    offc_valid <= 1'b1;
    offc_req   <= 16'h0001;
    offc_resp  <= 16'(r64());
    @(posedge pclk);
    evt_fx     <= 3'h0;
    offc_req   <= 16'h0002;
    @(posedge pclk);
    offc_valid <= 1'b0;
    rd(12'h058, 32'h00000001);
    rd(12'h020, 32'h00000001);
    wr(12'h05C, 32'h00000010);
    rd(12'h058, 32'h00000000);
    report_and_stop;
  end
endmodule
bind psr_top psr_top_props i_psr_top_props (.*);
`default_nettype wire
